// File: csc_pkg.sv
// Register map, field layouts and types of the calibration status block.
package csc_pkg;

	// ****************************************************************
	// Register offsets.
	// ****************************************************************
	localparam logic [7:0] CSC_OFS_STATUS   = 8'h6A;
	localparam logic [7:0] CSC_OFS_PIN_CFG  = 8'h6B;
	localparam logic [7:0] CSC_OFS_SW_TRIG  = 8'h6C;
	localparam logic [7:0] CSC_OFS_LP_CFG   = 8'h6E;
	localparam logic [7:0] CSC_OFS_IRQ_STAT = 8'h78;
	localparam logic [7:0] CSC_OFS_IRQ_MASK = 8'h79;

	// ****************************************************************
	// Reset values.
	// ****************************************************************
	localparam logic [7:0] CSC_RST_PIN_CFG  = 8'h00;
	localparam logic [7:0] CSC_RST_SW_TRIG  = 8'h01;
	localparam logic [7:0] CSC_RST_LP_CFG   = 8'h88;
	localparam logic [7:0] CSC_RST_IRQ_MASK = 8'h00;

	// ****************************************************************
	// Field positions.
	// ****************************************************************
	localparam int CSC_PIN_HW_SEL_BIT = 0;
	localparam int CSC_PIN_SRC_LSB    = 1;
	localparam int CSC_SW_TRIG_BIT    = 0;
	localparam int CSC_IRQ_FG_BIT     = 0;
	localparam int CSC_IRQ_HALT_BIT   = 1;
	localparam int CSC_IRQ_ALARM_BIT  = 2;
	localparam int CSC_IRQ_WAKE_BIT   = 3;
	localparam int CSC_IRQ_WIDTH      = 4;

	// ****************************************************************
	// Low-power delay figures, in clock periods.
	// ****************************************************************
	localparam int CSC_LP_UNIT_CYCLES = 256;
	localparam logic [5:0] CSC_SLEEP_EXP [8] = '{6'h03, 6'h0F, 6'h12, 6'h15,
		6'h18, 6'h1B, 6'h1E, 6'h21};
	localparam logic [5:0] CSC_WAKE_EXP [4] = '{6'h21, 6'h12, 6'h15, 6'h18};
	localparam int CSC_CNT_WIDTH = 48;

	// ****************************************************************
	// Types.
	// ****************************************************************
	typedef enum logic [1:0] {
		CSC_SRC_FG_COMPLETE,
		CSC_SRC_HALTED,
		CSC_SRC_ALARM,
		CSC_SRC_LOW
	} csc_pin_src_type;

	typedef struct packed {
		logic [2:0] lowpower_sleep_delay;
		logic [1:0] lowpower_wake_delay;
		logic       reserved;
		logic       lowpower_trigger_wake;
		logic       lowpower_bg_cal_enable;
	} csc_lp_cfg_type;

	typedef struct packed {
		logic [2:0] reserved;
		logic [2:0] state_code;
		logic       halted;
		logic       foreground_cal_complete;
	} csc_status_type;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} csc_bus_req_type;

	typedef struct packed {
		logic fg_finished;
		logic fg_skipped;
		logic bg_halted_at_phase;
		logic cal_resumed;
		logic cal_reset;
		logic alarm;
		logic core_cal_done;
	} csc_engine_evt_type;

endpackage

// File: csc_status_trigger.sv
// Calibration status, trigger source and low-power sequencing block.
// Notes on behaviour
// R01: The halted flag sets once background calibration rests at its phase.
// R02: The halted flag clears as soon as calibration runs again.
// R03: With background off, foreground finish or skip sets the halted flag.
// R04: The foreground-complete flag rises when foreground finishes or skips.
// R05: The pin-source field routes complete, halted, alarm or low to the pin.
// R06: Hardware select at 0 takes the software bit and ignores the pin.
// R07: Hardware select at 1 takes the pin and ignores the software bit.
// R08: The software trigger bit stands in for the pin level and resets high.
// R09: Software needing no trigger keeps select at 0 and the bit high.
// R10: Low-power config resets to 0x88; sleep delay 7:5, wake delay 4:3.
// R11: In autonomous mode a core sleeps (2^n + 1) times 256 clocks per code.
// R12: With trigger wake, a core sleeps until the trigger goes low.
// R13: Low-power calibration runs only while background calibration is on.
// R14: Writes to the status register are ignored and leave the flags alone.
`timescale 1ns/1ps
`default_nettype none

module csc_status_trigger #(
	parameter int NUM_CORES      = 3,
	parameter int LP_UNIT_CYCLES = 256,
	parameter int LP_EXP_CUT     = 0
) (
	input  wire logic                        ref_clk_in,
	input  wire logic                        reset_in,
	input  wire csc_pkg::csc_bus_req_type    bus_req_in,
	output var  logic [7:0]                  bus_rdata_out,
	input  wire csc_pkg::csc_engine_evt_type engine_evt_in,
	input  wire logic [2:0]                  state_code_in,
	input  wire logic                        background_cal_enable_in,
	input  wire logic                        cal_trigger_pin_in,
	output var  logic                        cal_trigger_out,
	output var  logic                        cal_state_pin_out,
	output var  logic [NUM_CORES-1:0]        core_sleep_out,
	output var  logic [NUM_CORES-1:0]        core_cal_req_out,
	output var  logic                        irq_out
);
	import csc_pkg::*;

	// ****************************************************************
	// Parameter checks.
	// ****************************************************************
	if (NUM_CORES < 1 || NUM_CORES > 8) begin : g_bad_cores
		$error("NUM_CORES must be 1 to 8.");
	end
	if (LP_UNIT_CYCLES < 1 || LP_UNIT_CYCLES > 256) begin : g_bad_unit
		$error("LP_UNIT_CYCLES must be 1 to 256.");
	end
	if (LP_EXP_CUT < 0 || LP_EXP_CUT > 3) begin : g_bad_cut
		$error("LP_EXP_CUT must be 0 to 3.");
	end

	typedef enum {
		LP_IDLE,
		LP_SLEEP,
		LP_WAKE,
		LP_CAL
	} csc_lp_state_type;

	localparam int CORE_W = 3;

	// ****************************************************************
	// Delay count from a table exponent.
	// ****************************************************************
	function automatic logic [CSC_CNT_WIDTH-1:0] delay_cycles(
		input logic [5:0] exp_code
	);
		logic [5:0]               e;
		logic [CSC_CNT_WIDTH-1:0] base;
		e = (exp_code > 6'(LP_EXP_CUT)) ? exp_code - 6'(LP_EXP_CUT) : 6'h00;
		base = (CSC_CNT_WIDTH'(1) << e) + CSC_CNT_WIDTH'(1);
		delay_cycles = CSC_CNT_WIDTH'(base * CSC_CNT_WIDTH'(LP_UNIT_CYCLES));
	endfunction

	// ****************************************************************
	// Software registers.
	// ****************************************************************
	logic                     hw_sel_r;
	logic                     hw_sel_nxt;
	csc_pin_src_type          pin_src_r;
	csc_pin_src_type          pin_src_nxt;
	logic                     sw_trig_r;
	logic                     sw_trig_nxt;
	csc_lp_cfg_type           lp_cfg_r;
	csc_lp_cfg_type           lp_cfg_nxt;
	logic [CSC_IRQ_WIDTH-1:0] irq_mask_r;
	logic [CSC_IRQ_WIDTH-1:0] irq_mask_nxt;
	logic                     wr_pin;
	logic                     wr_sw;
	logic                     wr_lp;
	logic                     wr_mask;

	always_comb begin
		wr_pin = bus_req_in.wr && bus_req_in.addr == CSC_OFS_PIN_CFG;
		wr_sw = bus_req_in.wr && bus_req_in.addr == CSC_OFS_SW_TRIG;
		wr_lp = bus_req_in.wr && bus_req_in.addr == CSC_OFS_LP_CFG;
		wr_mask = bus_req_in.wr && bus_req_in.addr == CSC_OFS_IRQ_MASK;
		hw_sel_nxt = hw_sel_r;
		pin_src_nxt = pin_src_r;
		sw_trig_nxt = sw_trig_r;
		lp_cfg_nxt = lp_cfg_r;
		irq_mask_nxt = irq_mask_r;
		if (wr_pin) begin
			hw_sel_nxt = bus_req_in.wdata[CSC_PIN_HW_SEL_BIT];
			pin_src_nxt = csc_pin_src_type'(
				bus_req_in.wdata[CSC_PIN_SRC_LSB +: 2]);
		end
		if (wr_sw) begin
			sw_trig_nxt = bus_req_in.wdata[CSC_SW_TRIG_BIT];
		end
		if (wr_lp) begin
			lp_cfg_nxt = csc_lp_cfg_type'(bus_req_in.wdata);
			lp_cfg_nxt.reserved = 1'b0;
		end
		if (wr_mask) begin
			irq_mask_nxt = bus_req_in.wdata[CSC_IRQ_WIDTH-1:0];
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			hw_sel_r <= CSC_RST_PIN_CFG[CSC_PIN_HW_SEL_BIT];
			pin_src_r <= csc_pin_src_type'(CSC_RST_PIN_CFG[CSC_PIN_SRC_LSB +: 2]);
			sw_trig_r <= CSC_RST_SW_TRIG[CSC_SW_TRIG_BIT]; // [R08]
			lp_cfg_r <= csc_lp_cfg_type'(CSC_RST_LP_CFG); // [R10]
			irq_mask_r <= CSC_RST_IRQ_MASK[CSC_IRQ_WIDTH-1:0];
		end else begin
			hw_sel_r <= hw_sel_nxt;
			pin_src_r <= pin_src_nxt;
			sw_trig_r <= sw_trig_nxt;
			lp_cfg_r <= lp_cfg_nxt;
			irq_mask_r <= irq_mask_nxt;
		end
	end

	// ****************************************************************
	// Status flags and interrupt status.
	// ****************************************************************
	logic                     fg_cmp_r;
	logic                     fg_cmp_nxt;
	logic                     halted_r;
	logic                     halted_nxt;
	logic                     alarm_r;
	logic                     alarm_nxt;
	logic [CSC_IRQ_WIDTH-1:0] irq_stat_r;
	logic [CSC_IRQ_WIDTH-1:0] irq_stat_nxt;
	logic [CSC_IRQ_WIDTH-1:0] irq_evt;
	logic                     fg_end;
	logic                     halt_set;
	logic                     wake_evt;

	always_comb begin
		fg_end = engine_evt_in.fg_finished || engine_evt_in.fg_skipped;
		halt_set = background_cal_enable_in ?
			engine_evt_in.bg_halted_at_phase : fg_end; // [R01] [R03]
		fg_cmp_nxt = fg_cmp_r;
		halted_nxt = halted_r;
		if (engine_evt_in.cal_reset) begin
			fg_cmp_nxt = 1'b0;
			halted_nxt = 1'b0;
		end
		if (engine_evt_in.cal_resumed) begin
			halted_nxt = 1'b0; // [R02]
		end
		if (fg_end) begin
			fg_cmp_nxt = 1'b1; // [R04]
		end
		if (halt_set) begin
			halted_nxt = 1'b1; // [R01]
		end
		alarm_nxt = engine_evt_in.alarm;
		irq_evt = '0;
		irq_evt[CSC_IRQ_FG_BIT] = fg_cmp_nxt && !fg_cmp_r;
		irq_evt[CSC_IRQ_HALT_BIT] = halted_nxt && !halted_r;
		irq_evt[CSC_IRQ_ALARM_BIT] = engine_evt_in.alarm && !alarm_r;
		irq_evt[CSC_IRQ_WAKE_BIT] = wake_evt;
		irq_stat_nxt = irq_stat_r;
		if (bus_req_in.wr && bus_req_in.addr == CSC_OFS_IRQ_STAT) begin
			irq_stat_nxt = irq_stat_r & ~bus_req_in.wdata[CSC_IRQ_WIDTH-1:0];
		end
		irq_stat_nxt = irq_stat_nxt | irq_evt;
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			fg_cmp_r <= 1'b0;
			halted_r <= 1'b0;
			alarm_r <= 1'b0;
			irq_stat_r <= '0;
		end else begin
			fg_cmp_r <= fg_cmp_nxt;
			halted_r <= halted_nxt;
			alarm_r <= alarm_nxt;
			irq_stat_r <= irq_stat_nxt;
		end
	end

	// ****************************************************************
	// Trigger source.
	// ****************************************************************
	logic trig_sel;

	always_comb begin
		if (hw_sel_r) begin
			trig_sel = cal_trigger_pin_in; // [R07]
		end else begin
			trig_sel = sw_trig_r; // [R06] [R08]
		end
	end

	// ****************************************************************
	// Low-power sequencer.
	// ****************************************************************
	csc_lp_state_type         lp_state_r;
	csc_lp_state_type         lp_state_nxt;
	logic [CSC_CNT_WIDTH-1:0] lp_cnt_r;
	logic [CSC_CNT_WIDTH-1:0] lp_cnt_nxt;
	logic [CORE_W-1:0]        core_r;
	logic [CORE_W-1:0]        core_nxt;
	logic                     lp_active;
	logic [CSC_CNT_WIDTH-1:0] sleep_cyc;
	logic [CSC_CNT_WIDTH-1:0] wake_cyc;

	always_comb begin
		lp_active = lp_cfg_r.lowpower_bg_cal_enable &&
			background_cal_enable_in; // [R13]
		sleep_cyc = delay_cycles(
			CSC_SLEEP_EXP[lp_cfg_r.lowpower_sleep_delay]); // [R11]
		wake_cyc = delay_cycles(CSC_WAKE_EXP[lp_cfg_r.lowpower_wake_delay]);
		lp_state_nxt = lp_state_r;
		lp_cnt_nxt = lp_cnt_r;
		core_nxt = core_r;
		wake_evt = 1'b0;
		if (!lp_active) begin
			lp_state_nxt = LP_IDLE;
			core_nxt = '0;
		end else begin
			unique case (lp_state_r)
				LP_IDLE: begin
					lp_state_nxt = LP_SLEEP;
					lp_cnt_nxt = sleep_cyc;
				end
				LP_SLEEP: begin
					if (lp_cfg_r.lowpower_trigger_wake) begin
						if (!trig_sel) begin // [R12]
							wake_evt = 1'b1;
						end
					end else if (lp_cnt_r <= CSC_CNT_WIDTH'(1)) begin // [R11]
						wake_evt = 1'b1;
					end else begin
						lp_cnt_nxt = lp_cnt_r - CSC_CNT_WIDTH'(1);
					end
					if (wake_evt) begin
						lp_state_nxt = LP_WAKE;
						lp_cnt_nxt = wake_cyc;
					end
				end
				LP_WAKE: begin
					if (lp_cnt_r <= CSC_CNT_WIDTH'(1)) begin
						lp_state_nxt = LP_CAL;
					end else begin
						lp_cnt_nxt = lp_cnt_r - CSC_CNT_WIDTH'(1);
					end
				end
				LP_CAL: begin
					if (engine_evt_in.core_cal_done) begin
						lp_state_nxt = LP_SLEEP;
						lp_cnt_nxt = sleep_cyc;
						if (core_r == CORE_W'(NUM_CORES - 1)) begin
							core_nxt = '0;
						end else begin
							core_nxt = core_r + CORE_W'(1);
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			lp_state_r <= LP_IDLE;
			lp_cnt_r <= '0;
			core_r <= '0;
		end else begin
			lp_state_r <= lp_state_nxt;
			lp_cnt_r <= lp_cnt_nxt;
			core_r <= core_nxt;
		end
	end

	// ****************************************************************
	// Outputs and read data.
	// ****************************************************************
	logic [7:0]           rdata_nxt;
	logic                 pin_nxt;
	logic [NUM_CORES-1:0] sleep_nxt;
	logic [NUM_CORES-1:0] req_nxt;
	csc_status_type       status_view;

	for (genvar i = 0; i < NUM_CORES; i++) begin : g_core
		assign sleep_nxt[i] = (lp_state_nxt == LP_SLEEP) &&
			core_nxt == CORE_W'(i);
		assign req_nxt[i] = (lp_state_nxt == LP_CAL) &&
			core_nxt == CORE_W'(i);
	end

	always_comb begin
		status_view = '0;
		status_view.state_code = state_code_in;
		status_view.halted = halted_r;
		status_view.foreground_cal_complete = fg_cmp_r;
		unique case (pin_src_r)
			CSC_SRC_FG_COMPLETE: pin_nxt = fg_cmp_r; // [R05]
			CSC_SRC_HALTED:  pin_nxt = halted_r; // [R05]
			CSC_SRC_ALARM:   pin_nxt = alarm_r; // [R05]
			CSC_SRC_LOW:     pin_nxt = 1'b0; // [R05]
		endcase
		rdata_nxt = 8'h00;
		if (bus_req_in.rd) begin
			unique case (bus_req_in.addr)
				CSC_OFS_STATUS:   rdata_nxt = status_view; // [R14]
				CSC_OFS_PIN_CFG:  rdata_nxt = {5'h00, pin_src_r, hw_sel_r};
				CSC_OFS_SW_TRIG:  rdata_nxt = {7'h00, sw_trig_r};
				CSC_OFS_LP_CFG:   rdata_nxt = lp_cfg_r;
				CSC_OFS_IRQ_STAT: rdata_nxt = 8'(irq_stat_r);
				CSC_OFS_IRQ_MASK: rdata_nxt = 8'(irq_mask_r);
				default:          rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			bus_rdata_out <= 8'h00;
			cal_trigger_out <= 1'b1;
			cal_state_pin_out <= 1'b0;
			core_sleep_out <= '0;
			core_cal_req_out <= '0;
			irq_out <= 1'b0;
		end else begin
			bus_rdata_out <= rdata_nxt;
			cal_trigger_out <= trig_sel;
			cal_state_pin_out <= pin_nxt;
			core_sleep_out <= sleep_nxt;
			core_cal_req_out <= req_nxt;
			irq_out <= |(irq_stat_nxt & irq_mask_r);
		end
	end

endmodule

`default_nettype wire

// File: csc_status_trigger_assertions.sv
// Assertion checker for the calibration status and trigger block.
`timescale 1ns/1ps
`default_nettype none
module csc_chk #(
	parameter int NUM_CORES = 3
) (
	input wire logic                        ref_clk_in,
	input wire logic                        reset_in,
	input wire csc_pkg::csc_bus_req_type    bus_req_in,
	input wire logic [7:0]                  bus_rdata_out,
	input wire csc_pkg::csc_engine_evt_type engine_evt_in,
	input wire logic                        background_cal_enable_in,
	input wire logic                        cal_trigger_pin_in,
	input wire logic                        cal_trigger_out,
	input wire logic                        cal_state_pin_out,
	input wire logic [NUM_CORES-1:0]        core_sleep_out,
	input wire logic [NUM_CORES-1:0]        core_cal_req_out
);
	import csc_pkg::*;
	// ****
	// Shadow registers and flags.
	// ****
	csc_bus_req_type    b;
	csc_engine_evt_type e;
	logic [2:0]         pc_r;
	logic [7:0]         lp_r;
	logic [7:0]         rv;
	logic               sw_r, fg_r, hl_r, al_r, hw, pin_e, act, fin, cfg;
	assign b = bus_req_in;
	assign e = engine_evt_in;
	assign hw = pc_r[0];
	assign fin = e.fg_finished | e.fg_skipped;
	assign act = lp_r[0] & background_cal_enable_in;
	assign cfg = b.addr == CSC_OFS_PIN_CFG || b.addr == CSC_OFS_SW_TRIG ||
		b.addr == CSC_OFS_LP_CFG;
	assign rv = b.addr == CSC_OFS_PIN_CFG ? {5'h00, pc_r} :
		b.addr == CSC_OFS_SW_TRIG ? {7'h00, sw_r} : lp_r;
	assign pin_e = pc_r[2:1] == 2'h0 ? fg_r : pc_r[2:1] == 2'h1 ? hl_r :
		pc_r[2:1] == 2'h2 ? al_r : 1'b0;
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			pc_r <= 3'h0;
			sw_r <= 1'b1;
			lp_r <= 8'h88;
			fg_r <= 1'b0;
			hl_r <= 1'b0;
			al_r <= 1'b0;
		end else begin
			if (b.wr && b.addr == CSC_OFS_PIN_CFG) pc_r <= b.wdata[2:0];
			if (b.wr && b.addr == CSC_OFS_SW_TRIG) sw_r <= b.wdata[0];
			if (b.wr && b.addr == CSC_OFS_LP_CFG) lp_r <= b.wdata & 8'hFB;
			fg_r <= fin | (fg_r & ~e.cal_reset);
			hl_r <= (background_cal_enable_in ? e.bg_halted_at_phase : fin) |
				(hl_r & ~e.cal_resumed & ~e.cal_reset);
			al_r <= e.alarm;
		end
	end
	// ****
	// Properties.
	// ****
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);
	AST_TRIG_SW: assert property (!$past(hw) |->
		cal_trigger_out == $past(sw_r)) else $error("trigger not from bit");
	AST_TRIG_HW: assert property ($past(hw) |->
		cal_trigger_out == $past(cal_trigger_pin_in))
		else $error("trigger not from pin");
	AST_FG: assert property (b.rd && b.addr == CSC_OFS_STATUS |=>
		bus_rdata_out[0] == $past(fg_r)) else $error("complete flag wrong");
	AST_HALT: assert property (
		b.rd && b.addr == CSC_OFS_STATUS |=>
		bus_rdata_out[1] == $past(hl_r)) else $error("halted flag wrong");
	AST_PIN: assert property (cal_state_pin_out == $past(pin_e))
		else $error("status pin wrong");
	AST_RD: assert property (b.rd && cfg |=>
		bus_rdata_out == $past(rv)) else $error("register read wrong");
	AST_LP_OFF: assert property (!$past(act) && !$past(act, 2) |->
		core_sleep_out == '0 && core_cal_req_out == '0)
		else $error("core active while low power is off");
	AST_ONEHOT: assert property ($onehot0(core_sleep_out))
		else $error("more than one core asleep");
endmodule
bind csc_status_trigger csc_chk #(.NUM_CORES(NUM_CORES)) csc_chk_i (
	.ref_clk_in, .reset_in, .bus_req_in, .bus_rdata_out, .engine_evt_in,
	.background_cal_enable_in, .cal_trigger_pin_in, .cal_trigger_out,
	.cal_state_pin_out, .core_sleep_out, .core_cal_req_out);
`default_nettype wire

// File: csc_host_model.sv
// Host model that drives the external calibration trigger pin.
`timescale 1ns/1ps
`default_nettype none
module csc_host_model (
	input  wire logic ref_clk_in,
	input  wire logic reset_in,
	input  wire logic trig_lvl_in,
	output var  logic cal_trigger_pin_out
);
	// ****
	// Pin driver, idle high.
	// ****
	logic pin_nxt;
	assign pin_nxt = reset_in ? 1'b1 : trig_lvl_in;
	always_ff @(posedge ref_clk_in) begin
		cal_trigger_pin_out <= pin_nxt;
	end
endmodule
`default_nettype wire

// File: tb.sv
// Testbench of the calibration status and trigger block.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import csc_pkg::*;
	localparam int UNIT = 1;
	localparam int CUT  = 3;
	logic            ref_clk, rst, bg, lvl, pin, trig, spin, irq;
	csc_bus_req_type bus;
	logic [6:0]      evt;
	logic [7:0]      rdata;
	logic [2:0]      sleep, req;
	logic [3:0]      tbl [2] = '{4'b0011, 4'b0100};
	int              bad_count = 0, tests_run = 0, cycles = 0, n;
	csc_status_trigger #(.LP_UNIT_CYCLES(UNIT), .LP_EXP_CUT(CUT))
	csc_status_trigger_i (.ref_clk_in(ref_clk), .reset_in(rst),
		.bus_req_in(bus), .bus_rdata_out(rdata), .engine_evt_in(evt),
		.state_code_in(3'h5), .background_cal_enable_in(bg),
		.cal_trigger_pin_in(pin), .cal_trigger_out(trig),
		.cal_state_pin_out(spin), .core_sleep_out(sleep),
		.core_cal_req_out(req), .irq_out(irq));
	csc_host_model csc_host_model_i (.ref_clk_in(ref_clk), .reset_in(rst),
		.trig_lvl_in(lvl), .cal_trigger_pin_out(pin));
	// ****
	// Clock, timeout and tasks.
	// ****
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 40000) begin
			bad_count++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("tests_run %0d bad_count %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] s, x);
		tests_run++;
		if (s !== x) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, x, s);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge ref_clk);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge ref_clk);
		bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, x);
		@(posedge ref_clk);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge ref_clk);
		bus.rd <= 1'b0;
		#1 chk("rdata", rdata, x);
	endtask
	task automatic ev(input logic [6:0] e);
		@(posedge ref_clk);
		evt <= evt | e;
		@(posedge ref_clk);
		evt <= evt & 7'h02;
	endtask
	// ****
	// Tests.
	// ****
	initial begin
		bus = '0;
		evt = 7'h00;
		bg = 1'b0;
		lvl = 1'b0;
		rst = 1'b1;
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		rd(CSC_OFS_PIN_CFG, 8'h00);
		rd(CSC_OFS_SW_TRIG, 8'h01);
		rd(CSC_OFS_LP_CFG, 8'h88);
		rd(CSC_OFS_STATUS, 8'h14);
		rd(8'h50, 8'h00);
		wr(CSC_OFS_LP_CFG, 8'hF6);
		rd(CSC_OFS_LP_CFG, 8'hF2);
		$display("test registers done");
		ev(7'h20);
		rd(CSC_OFS_STATUS, 8'h17);
		wr(CSC_OFS_STATUS, 8'h00);
		rd(CSC_OFS_STATUS, 8'h17);
		ev(7'h08);
		rd(CSC_OFS_STATUS, 8'h15);
		ev(7'h04);
		rd(CSC_OFS_STATUS, 8'h14);
		@(posedge ref_clk) bg <= 1'b1;
		ev(7'h40);
		rd(CSC_OFS_STATUS, 8'h15);
		ev(7'h10);
		rd(CSC_OFS_STATUS, 8'h17);
		@(posedge ref_clk) bg <= 1'b0;
		$display("test status done");
		for (int p = 0; p < 2; p++) begin
			for (int s = 0; s < 4; s++) begin
				wr(CSC_OFS_PIN_CFG, 8'(s * 2));
				cyc(3);
				chk("pin", {7'h00, spin}, {7'h00, tbl[p][s]});
			end
			ev(7'h04);
			@(posedge ref_clk) evt[1] <= 1'b1;
		end
		$display("test pin done");
		wr(CSC_OFS_PIN_CFG, 8'h00);
		cyc(2);
		chk("trig", {7'h00, trig}, 8'h01);
		wr(CSC_OFS_SW_TRIG, 8'h00);
		cyc(2);
		chk("trig", {7'h00, trig}, 8'h00);
		@(posedge ref_clk) lvl <= 1'b1;
		wr(CSC_OFS_PIN_CFG, 8'h01);
		cyc(3);
		chk("trig", {7'h00, trig}, 8'h01);
		@(posedge ref_clk) lvl <= 1'b0;
		wr(CSC_OFS_SW_TRIG, 8'h01);
		cyc(3);
		chk("trig", {7'h00, trig}, 8'h00);
		wr(CSC_OFS_PIN_CFG, 8'h00);
		$display("test trigger done");
		wr(CSC_OFS_IRQ_STAT, 8'h0F);
		wr(CSC_OFS_IRQ_MASK, 8'h00);
		ev(7'h40);
		rd(CSC_OFS_IRQ_STAT, 8'h03);
		chk("irq", {7'h00, irq}, 8'h00);
		wr(CSC_OFS_IRQ_MASK, 8'h01);
		cyc(2);
		chk("irq", {7'h00, irq}, 8'h01);
		wr(CSC_OFS_IRQ_STAT, 8'h01);
		cyc(2);
		chk("irq", {7'h00, irq}, 8'h00);
		rd(CSC_OFS_IRQ_STAT, 8'h02);
		$display("test interrupt done");
		wr(CSC_OFS_LP_CFG, 8'h09);
		cyc(5);
		chk("sleep", {5'h00, sleep}, 8'h00);
		@(posedge ref_clk) bg <= 1'b1;
		n = 0;
		while (sleep[0] !== 1'b1 && n < 20) begin
			cyc(1);
			n++;
		end
		n = 0;
		while (sleep[0] === 1'b1 && n < 50) begin
			cyc(1);
			n++;
		end
		chk("sleep_len", 8'(n),
			8'(((1 << (CSC_SLEEP_EXP[0] - CUT)) + 1) * UNIT));
		@(posedge ref_clk) bg <= 1'b0;
		cyc(3);
		chk("lp_off", {2'h0, sleep, req}, 8'h00);
		wr(CSC_OFS_LP_CFG, 8'h0B);
		@(posedge ref_clk) bg <= 1'b1;
		cyc(20);
		chk("sleep", {5'h00, sleep}, 8'h01);
		wr(CSC_OFS_SW_TRIG, 8'h00);
		cyc(4);
		chk("sleep", {5'h00, sleep}, 8'h00);
		n = 0;
		while (req !== 3'h1 && n < 33000) begin
			cyc(1);
			n++;
		end
		chk("cal_req", {5'h00, req}, 8'h01);
		wr(CSC_OFS_SW_TRIG, 8'h01);
		ev(7'h01);
		cyc(2);
		chk("next_core", {2'h0, sleep, req}, 8'h10);
		rd(CSC_OFS_IRQ_STAT, 8'h0A);
		$display("test low power done");
		report_and_stop();
	end
endmodule
`default_nettype wire
